// ---- inc/acs_defs.vh ----
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_CMD 8'h04
`define ACS_OFF_STAT 8'h08
`define ACS_OFF_RES0 8'h10
`define ACS_OFF_RES1 8'h14
`define ACS_OFF_RES2 8'h18
`define ACS_OFF_RES3 8'h1c

// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define ACS_CTRL_RES_LSB 0
`define ACS_CTRL_DIFF_BIT 3
`define ACS_CTRL_EN_LSB 4
`define ACS_RES_SEL_RST 3'h5
`define ACS_RES_SEL_MAX 3'h5
`define ACS_CH_EN_RST 4'hf
`define ACS_CMD_GO_BIT 0
`define ACS_STAT_BUSY_BIT 0
`define ACS_STAT_DONE_BIT 1

// ---------------------------------------------
// resolution and channel codes
// ---------------------------------------------
`define ACS_RES_MIN_BITS 4'h7
`define ACS_CH_IN0 2'h0
`define ACS_CH_IN1 2'h1
`define ACS_CH_TEMP 2'h2
`define ACS_CH_SUPPLY3 2'h3
`define ACS_CH_NONE 3'h4

// ---------------------------------------------
// timing
// ---------------------------------------------
`define ACS_PCLK_MHZ 8'h7d
`define ACS_SYS_MHZ 8'h20
`define ACS_SYS_DIV 4'h8
`define ACS_CONV_NS 250
`define ACS_SETTLE_CYC 5'h10

`endif

// ---- hw/acs_clkdiv.v ----
`include "acs_defs.vh"

module acs_clkdiv (
    input wire clk, // bus clock
    input wire rst_n, // async reset, active low
    output reg conv_tick // one-cycle conversion clock enable
);

// ---------------------------------------------
// fractional system-clock rate, then divide by 8
// ---------------------------------------------
localparam [7:0] STEP = `ACS_SYS_MHZ;
localparam [7:0] WRAP = `ACS_PCLK_MHZ;
localparam [3:0] LAST = `ACS_SYS_DIV - 4'h1;

reg [7:0] acc_reg;
reg [2:0] div_reg;
wire [7:0] acc_sum = acc_reg + STEP;
wire sys_tick = (acc_sum >= WRAP);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        acc_reg <= 8'h00;
        div_reg <= 3'h0;
        conv_tick <= 1'b0;
    end else begin
        acc_reg <= sys_tick ? (acc_sum - WRAP) : acc_sum;
        conv_tick <= 1'b0;
        if (sys_tick) begin
            div_reg <= div_reg + 3'h1; // see RULE12
            conv_tick <= ({1'b0, div_reg} == LAST);
        end
    end
end

endmodule

// ---- hw/acs_decim.v ----
module acs_decim (
    input wire clk, // bus clock
    input wire rst_n, // async reset, active low
    input wire tick, // conversion clock enable
    input wire start, // begin one conversion
    input wire [3:0] rate_log, // resolution in bits, 7..12
    input wire bit_in, // synchronised modulator bit
    output reg done, // result valid pulse
    output reg [12:0] val // signed result
);

// ---------------------------------------------
// incremental ones counter over 2**bits periods
// ---------------------------------------------
reg busy_reg;
reg [12:0] left_reg;
reg [12:0] ones_reg;
wire [12:0] rate = 13'h0001 << rate_log;
wire [12:0] half = rate >> 1;
wire [12:0] ones_nx = ones_reg + {12'h000, bit_in};
wire [12:0] diffv = ones_nx - half;
wire [12:0] maxv = half - 13'h0001;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        busy_reg <= 1'b0;
        left_reg <= 13'h0000;
        ones_reg <= 13'h0000;
        done <= 1'b0;
        val <= 13'h0000;
    end else begin
        done <= 1'b0;
        if (start) begin
            busy_reg <= 1'b1;
            left_reg <= rate; // see RULE1
            ones_reg <= 13'h0000;
        end else if (busy_reg && tick) begin
            ones_reg <= ones_nx;
            left_reg <= left_reg - 13'h0001; // see RULE13
            if (left_reg == 13'h0001) begin
                busy_reg <= 1'b0;
                done <= 1'b1;
                // full scale clips to +2**(n-1)-1
                val <= ($signed(diffv) > $signed(maxv)) ? maxv : diffv; // see RULE9 see RULE10
            end
        end
    end
end

endmodule

// ---- hw/acs_top.v ----
// Contract
// RULE1: decimation rate is selectable and sets resolution from 7 to 12 bits.
// RULE2: the two pins work as two single-ended channels or one differential pair.
// RULE3: a read command runs a whole conversion sequence without host help.
// RULE4: channels are converted one after another in increasing order.
// RULE5: the on-chip temperature sensor can be selected as an input.
// RULE6: one third of the analog supply can be selected for battery monitoring.
// RULE7: differential mode converts the pair difference, which may be negative.
// RULE8: results are two's complement; single-ended results are never negative.
// RULE9: at 12 bits, +reference gives 2047 and -reference gives -2048.
// RULE10: single-ended full-scale code is reached when input equals the reference.
// RULE11: the positive reference is the internal 1.25 V reference.
// RULE12: conversion clock is the 32 MHz system clock divided by eight.
// RULE13: a conversion takes exactly as many conversion periods as the rate.
// RULE14: after a channel change wait 16 conversion cycles before converting.
// RULE15: hold sign-extended results until the sequence ends, then flag completion.
// RULE16: a read command during a running sequence is ignored.
`include "acs_defs.vh"

module acs_top (
    input wire pclk, // bus clock, 125 MHz
    input wire presetn, // async reset, active low
    input wire [7:0] paddr, // apb address
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error
    input wire mod_bit, // modulator bitstream from analog core
    output reg [1:0] mux_sel, // analog input select
    output reg diff_mode, // pair as differential input
    output reg vref_int, // internal reference select
    output reg mod_run, // modulator running
    output reg seq_busy, // sequence in progress
    output reg seq_done // results ready
);

// ---------------------------------------------
// states
// ---------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_PICK = 3'h1;
localparam [2:0] ST_SETTLE = 3'h2;
localparam [2:0] ST_CONV = 3'h3;
localparam [2:0] ST_WAIT = 3'h4;
localparam [2:0] ST_FIN = 3'h5;

reg [2:0] res_sel_reg;
reg [3:0] ch_en_reg;
reg [2:0] state_reg;
reg [1:0] idx_reg;
reg [2:0] last_ch_reg;
reg [4:0] settle_reg;
reg dec_start_reg;
wire [127:0] res_flat;
reg sync1_reg;
reg sync2_reg;
reg sync3_reg;
reg mod_stable_reg;
reg [31:0] rd_data;
reg rd_err;

wire conv_tick;
wire dec_done;
wire [12:0] dec_val;
wire [3:0] res_bits = {1'b0, res_sel_reg} + `ACS_RES_MIN_BITS;

// ---------------------------------------------
// apb decode
// ---------------------------------------------
wire acc_phase = psel & penable;
wire wr_fire = acc_phase & pready & pwrite;
wire cmd_go = wr_fire && (paddr == `ACS_OFF_CMD) && pwdata[`ACS_CMD_GO_BIT];
wire done_clr = wr_fire && (paddr == `ACS_OFF_STAT) && pwdata[`ACS_STAT_DONE_BIT];
wire ch_skip = !ch_en_reg[idx_reg] || (diff_mode && (idx_reg == `ACS_CH_IN1));
wire se_conv = !(diff_mode && (idx_reg == `ACS_CH_IN0));
wire seq_end = (state_reg == ST_FIN);

// ---------------------------------------------
// sub-blocks
// ---------------------------------------------
acs_clkdiv u_div (
    .clk(pclk),
    .rst_n(presetn),
    .conv_tick(conv_tick)
);

acs_decim u_dec (
    .clk(pclk),
    .rst_n(presetn),
    .tick(conv_tick),
    .start(dec_start_reg),
    .rate_log(res_bits),
    .bit_in(mod_stable_reg),
    .done(dec_done),
    .val(dec_val)
);

// ---------------------------------------------
// modulator bit synchroniser
// ---------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
        sync3_reg <= 1'b0;
        mod_stable_reg <= 1'b0;
    end else begin
        sync1_reg <= mod_bit;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        if (sync2_reg == sync3_reg) begin
            mod_stable_reg <= sync3_reg;
        end
    end
end

// ---------------------------------------------
// register read mux
// ---------------------------------------------
always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
        `ACS_OFF_CTRL: begin
            rd_data[`ACS_CTRL_RES_LSB +: 3] = res_sel_reg;
            rd_data[`ACS_CTRL_DIFF_BIT] = diff_mode;
            rd_data[`ACS_CTRL_EN_LSB +: 4] = ch_en_reg;
        end
        `ACS_OFF_CMD: rd_data = 32'h0000_0000;
        `ACS_OFF_STAT: begin
            rd_data[`ACS_STAT_BUSY_BIT] = seq_busy;
            rd_data[`ACS_STAT_DONE_BIT] = seq_done;
        end
        `ACS_OFF_RES0: rd_data = res_flat[31:0];
        `ACS_OFF_RES1: rd_data = res_flat[63:32];
        `ACS_OFF_RES2: rd_data = res_flat[95:64];
        `ACS_OFF_RES3: rd_data = res_flat[127:96];
        default: rd_err = 1'b1;
    endcase
end

// ---------------------------------------------
// apb slave, one wait state
// ---------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end else begin
        if (acc_phase && !pready) begin
            pready <= 1'b1;
            pslverr <= rd_err;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
end

// ---------------------------------------------
// configuration register
// ---------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        res_sel_reg <= `ACS_RES_SEL_RST;
        ch_en_reg <= `ACS_CH_EN_RST;
        diff_mode <= 1'b0;
    end else begin
        // configuration is frozen while a sequence runs
        if (wr_fire && (paddr == `ACS_OFF_CTRL) && !seq_busy) begin
            if (pwdata[`ACS_CTRL_RES_LSB +: 3] > `ACS_RES_SEL_MAX) begin
                res_sel_reg <= `ACS_RES_SEL_MAX; // see RULE1
            end else begin
                res_sel_reg <= pwdata[`ACS_CTRL_RES_LSB +: 3]; // see RULE1
            end
            diff_mode <= pwdata[`ACS_CTRL_DIFF_BIT]; // see RULE2
            ch_en_reg <= pwdata[`ACS_CTRL_EN_LSB +: 4];
        end
    end
end

// ---------------------------------------------
// conversion sequencer
// ---------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= ST_IDLE;
        idx_reg <= 2'h0;
        last_ch_reg <= `ACS_CH_NONE;
        settle_reg <= 5'h00;
        dec_start_reg <= 1'b0;
        mux_sel <= `ACS_CH_IN0;
        vref_int <= 1'b0;
        mod_run <= 1'b0;
        seq_busy <= 1'b0;
    end else begin
        dec_start_reg <= 1'b0;
        vref_int <= 1'b1; // see RULE11
        case (state_reg)
            ST_IDLE: begin
                if (cmd_go) begin
                    seq_busy <= 1'b1; // see RULE3
                    idx_reg <= 2'h0;
                    state_reg <= ST_PICK;
                end
            end
            ST_PICK: begin
                if (ch_skip) begin
                    idx_reg <= idx_reg + 2'h1; // see RULE4
                    if (idx_reg == `ACS_CH_SUPPLY3) begin
                        state_reg <= ST_FIN;
                    end
                end else begin
                    // temp sensor and supply/3 sit at codes 2 and 3
                    mux_sel <= idx_reg; // see RULE5 see RULE6
                    mod_run <= 1'b1;
                    settle_reg <= `ACS_SETTLE_CYC;
                    if ({1'b0, idx_reg} != last_ch_reg) begin
                        state_reg <= ST_SETTLE; // see RULE14
                    end else begin
                        state_reg <= ST_CONV;
                    end
                end
            end
            ST_SETTLE: begin
                if (conv_tick) begin
                    settle_reg <= settle_reg - 5'h01;
                    if (settle_reg == 5'h01) begin
                        state_reg <= ST_CONV; // see RULE14
                    end
                end
            end
            ST_CONV: begin
                dec_start_reg <= 1'b1;
                last_ch_reg <= {1'b0, idx_reg};
                state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
                if (dec_done) begin
                    idx_reg <= idx_reg + 2'h1; // see RULE4
                    if (idx_reg == `ACS_CH_SUPPLY3) begin
                        state_reg <= ST_FIN;
                    end else begin
                        state_reg <= ST_PICK;
                    end
                end
            end
            ST_FIN: begin
                mod_run <= 1'b0;
                seq_busy <= 1'b0; // see RULE16
                state_reg <= ST_IDLE;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

// ---------------------------------------------
// result store, one word per channel
// ---------------------------------------------
wire res_take = (state_reg == ST_WAIT) && dec_done;
wire [3:0] res_hit = 4'h1 << idx_reg;
// single-ended negatives clamp to zero, the pair difference stays signed
wire [31:0] res_word = (se_conv && dec_val[12]) ? 32'h0000_0000 : {{19{dec_val[12]}}, dec_val}; // see RULE7 see RULE8

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_res
        reg [31:0] word_reg;
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                word_reg <= 32'h0000_0000;
            end else if (res_take && res_hit[g]) begin
                word_reg <= res_word; // see RULE15
            end
        end
        assign res_flat[32 * g +: 32] = word_reg;
    end
endgenerate

// ---------------------------------------------
// completion flag
// ---------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        seq_done <= 1'b0;
    end else begin
        // completion wins over a clear in the same cycle
        if (seq_end) begin
            seq_done <= 1'b1; // see RULE15
        end else if (done_clr) begin
            seq_done <= 1'b0;
        end
    end
end

endmodule

// ---- verification/acs_monitor.sv ----
module acs_monitor (
    input wire pclk, // bus clock
    input wire presetn, // reset, active low
    input wire [7:0] paddr, // apb address
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [31:0] pwdata, // apb write data
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire mod_bit, // modulator bitstream
    input wire [1:0] mux_sel, // input select
    input wire diff_mode, // pair mode
    input wire vref_int, // reference select
    input wire mod_run, // modulator running
    input wire seq_busy, // sequence running
    input wire seq_done // results ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // only word 3 is a hole below 0x20
    wire mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) && (paddr[4:2] != 3'h3);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_go_busy: assert property (pready && psel && pwrite && paddr == 8'h04 && pwdata[0] && !seq_busy |-> ##[1:2] seq_busy)
        else $error("go did not start sequence");
    a_run_busy: assert property (mod_run |-> seq_busy)
        else $error("modulator runs outside sequence");
    a_ascending: assert property (mod_run && $past(mod_run) && mux_sel != $past(mux_sel) |-> mux_sel > $past(mux_sel))
        else $error("channel order not ascending");
    a_diff_skip: assert property (mod_run && diff_mode |-> mux_sel != 2'h1)
        else $error("second pin converted in pair mode");
    a_ref_int: assert property (mod_run |-> vref_int)
        else $error("conversion without internal reference");
    a_done_end: assert property ($fell(seq_busy) |-> seq_done && !mod_run)
        else $error("sequence ended without completion");
    a_ctrl_hold: assert property (seq_busy && $past(seq_busy) |-> $stable(diff_mode))
        else $error("mode changed during sequence");
endmodule

bind acs_top acs_monitor u_acs_monitor (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_bit(mod_bit), .mux_sel(mux_sel), .diff_mode(diff_mode),
    .vref_int(vref_int), .mod_run(mod_run), .seq_busy(seq_busy), .seq_done(seq_done));

// ---- verification/acs_analog.sv ----
module acs_analog (
    input wire pclk, // bus clock
    input wire presetn, // reset, active low
    input wire [1:0] mux_sel, // selected input
    input wire mod_run, // modulator running
    input wire [3:0] level, // per input, 1 is full reference
    output reg mod_bit // modulator bitstream
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle output toggles so stale bits never look valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_bit <= 1'b0;
        end else if (mod_run) begin
            mod_bit <= level[mux_sel];
        end else begin
            mod_bit <= ~mod_bit;
        end
    end
endmodule

// ---- verification/acs_top_test.sv ----
module acs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [3:0] lev;
        logic [127:0] res;
        integer dur;
    } acs_row_t;
    logic pclk = 0;
    logic presetn = 0;
    logic [7:0] paddr = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] pwdata = 0;
    logic [3:0] lev = 0;
    wire [31:0] prdata;
    wire pready, pslverr, mod_bit, diff_mode, vref_int, mod_run, seq_busy, seq_done;
    wire [1:0] mux_sel;
    integer mismatches = 0;
    integer n_compared = 0;
    integer busy_len = 0;
    integer i, j, t0;
    logic [31:0] q;
    logic e;
    acs_row_t rows [3];
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (seq_busy === 1'b1) busy_len <= busy_len + 1;
    acs_top u_acs_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mod_bit(mod_bit), .mux_sel(mux_sel), .diff_mode(diff_mode), .vref_int(vref_int),
        .mod_run(mod_run), .seq_busy(seq_busy), .seq_done(seq_done));
    acs_analog u_acs_analog (.pclk(pclk), .presetn(presetn), .mux_sel(mux_sel), .mod_run(mod_run),
        .level(lev), .mod_bit(mod_bit));
    task stop_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] x, input [31:0] g);
        begin
            n_compared++;
            if (g !== x) begin
                mismatches++;
                $display("FAIL %s expected %h seen %h", nm, x, g);
            end
        end
    endtask
    task rng(input string nm, input integer lo, input integer hi, input integer v);
        begin
            n_compared++;
            if (v < lo || v > hi) begin
                mismatches++;
                $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, v);
            end
        end
    endtask
    // ---------------------------------------------
    // apb master, one wait state expected
    // ---------------------------------------------
    task apb(input logic w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1;
            penable <= 0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            for (k = 0; k < 50; k++) begin
                @(posedge pclk);
                if (pready === 1'b1) break;
            end
            if (k == 50) begin
                mismatches++;
                $display("FAIL pready expected 1 seen 0");
                stop_test;
            end
            q = prdata;
            e = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] x);
        begin
            apb(0, a, 0);
            chk($sformatf("reg %h", a), x, q);
        end
    endtask
    task run_seq(input [31:0] c);
        begin
            apb(1, 8'h00, c);
            apb(1, 8'h08, 32'h2);
            apb(1, 8'h04, 32'h1);
            t0 = busy_len;
        end
    endtask
    task wait_done;
        integer k;
        begin
            for (k = 0; k < 20000 && seq_done !== 1'b1; k++) @(posedge pclk);
            if (k == 20000) begin
                mismatches++;
                $display("FAIL seq_done expected 1 seen 0");
                stop_test;
            end
        end
    endtask
    initial begin
        rows[0] = {32'hf0, 4'b1101, 32'h3f, 32'h0, 32'h3f, 32'h3f, 32'd18000};
        rows[1] = {32'h18, 4'b1100, 32'hffffffc0, 32'h0, 32'h3f, 32'h3f, 32'd4500};
        rows[2] = {32'h21, 4'b0010, 32'hffffffc0, 32'h7f, 32'h3f, 32'h3f, 32'd8500};
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rdc(8'h00, 32'hf5);
        rdc(8'h08, 32'h0);
        chk("vref_int", 1, vref_int);
        apb(0, 8'h0c, 0);
        chk("pslverr", 1, e);
        chk("prdata", 0, q);
        apb(1, 8'h00, 32'hf7);
        rdc(8'h00, 32'hf5);
        for (i = 0; i < 3; i++) begin
            lev <= rows[i].lev;
            run_seq(rows[i].ctrl);
            wait_done;
            rng("busy cycles", rows[i].dur - 40, rows[i].dur + 160, busy_len - t0);
            for (j = 0; j < 4; j++) rdc(8'h10 + 8'(4 * j), rows[i].res[127 - 32 * j -: 32]);
            if (i == 0) apb(1, 8'h18, 32'h55);
        end
        lev <= 4'hf;
        run_seq(32'h10);
        apb(1, 8'h04, 32'h1);
        apb(1, 8'h00, 32'hf5);
        rdc(8'h08, 32'h1);
        rdc(8'h04, 32'h0);
        wait_done;
        rdc(8'h00, 32'h10);
        rdc(8'h10, 32'h3f);
        repeat (40) @(posedge pclk);
        chk("seq_busy", 0, seq_busy);
        run_seq(32'h10);
        wait_done;
        rng("busy cycles", 3960, 4160, busy_len - t0);
        rdc(8'h10, 32'h3f);
        rdc(8'h08, 32'h2);
        apb(1, 8'h08, 32'h2);
        rdc(8'h08, 32'h0);
        run_seq(32'h21);
        repeat (100) @(posedge pclk);
        presetn <= 0;
        repeat (5) @(posedge pclk);
        chk("seq_busy", 0, seq_busy);
        chk("mod_run", 0, mod_run);
        presetn <= 1;
        rdc(8'h00, 32'hf5);
        rdc(8'h14, 32'h0);
        rdc(8'h08, 32'h0);
        stop_test;
    end
endmodule
